// [rtl/clock_gen_config_control.sv]
// Purpose: configuration storage, set selection and output routing of a 4-pll generator
// Assumes: a serial engine hands over decoded config requests; pll ticks arrive as pulses
// Notes: analog pll, crystal and pad levels live outside
`timescale 1ns/10ps
module clock_gen_config_control
    import clkgen_pkg::*;
#(
    parameter int NUM_MF = 2
) (
    input wire logic core_clk_in, // core clock, 20 MHz
    input wire logic rst_in, // synchronous reset
    input wire logic [SET_IDX_W-1:0] freq_select_pins_in, // set select pins
    input wire logic [NUM_MF-1:0] mf_pins_in, // multifunction pins
    input wire mf_func_e [NUM_MF-1:0] mf_func_in, // function of each pin
    input wire logic [NUM_PLL-1:0] pll_tick_in, // pll edge pulses
    input wire logic ref2_tick_in, // secondary reference edge
    input wire logic signed [9:0] control_voltage_input_in, // trim, ppm units
    input wire logic [6:0] bus_addr_in, // addressed target from engine
    input wire logic addr_wr_in, // program new target address
    input wire logic [6:0] addr_new_in, // new target address
    input wire prot_e prot_in, // profile protection mode
    input wire cfg_req_s req_in, // config request
    input wire logic [NUM_SETS-1:0] part_mask_in, // divider mask for partial write
    output logic addr_match_out, // engine may acknowledge
    output logic [6:0] bus_addr_out, // current target address
    output cfg_set_s rd_data_out, // read back data
    output logic req_refused_out, // protection refused last request
    output logic [SET_IDX_W-1:0] active_set_out, // set in use
    output logic [BANK_OUTS-1:0] bank_a_out, // bank a clocks
    output logic [BANK_OUTS-1:0] bank_b_out, // bank b clocks
    output logic [DUAL_OUTS-1:0] bank_a_diff_out, // bank a dual-mode differential
    output logic [DUAL_OUTS-1:0] bank_b_diff_out, // bank b dual-mode differential
    output logic [NUM_PLL-1:0] pll_fb_ref2_out, // feedback from secondary ref
    output logic signed [9:0] pll1_frac_trim_out, // pll 1 fractional offset
    output logic spread_en_out, // spread modulation on
    output logic power_down_out, // core power down
    output logic lf_clk_out // low-frequency output
);
    localparam int ND = NUM_PLL * DIVS_PER_PLL;

    typedef struct packed {
        cfg_set_s [NUM_SETS-1:0] sets;
        cfg_set_s profile;
        logic [6:0] addr;
        logic [SET_IDX_W-1:0] active;
        logic [NUM_PLL-1:0] resync;
        cfg_set_s rd;
        logic refused;
        logic match;
        logic [BANK_OUTS-1:0] bank_a;
        logic [BANK_OUTS-1:0] bank_b;
        logic [DUAL_OUTS-1:0] diff_a;
        logic [DUAL_OUTS-1:0] diff_b;
        logic [NUM_PLL-1:0] fb;
        logic signed [9:0] trim;
        logic spread;
        logic pdown;
        logic oe;
        logic fsel_hold;
        logic [LF_W-1:0] lf_cnt;
        logic lf;
    } st_s;
    st_s st_reg, st_next;

    logic [SET_IDX_W-1:0] fs_level;
    logic fs_change;
    logic [ND-1:0] div_clk;
    logic [ND-1:0] div_tick;

    // -----------------------------------------------------------
    // select pin conditioning
    // -----------------------------------------------------------
    sel_debounce #(
        .W(SET_IDX_W)
    ) u_fsel (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .pins_in(freq_select_pins_in),
        .level_out(fs_level),
        .change_out(fs_change)
    );

    // -----------------------------------------------------------
    // dividers, four per pll
    // -----------------------------------------------------------
    cfg_set_s cur;
    assign cur = st_reg.sets[st_reg.active];

    for (genvar d = 0; d < ND; d++) begin : g_div
        // feedback mode retimes the pll group from the secondary reference
        assign div_tick[d] = st_reg.fb[d / DIVS_PER_PLL] ? ref2_tick_in
                                                         : pll_tick_in[d / DIVS_PER_PLL];
        out_divider u_div (
            .core_clk_in(core_clk_in),
            .rst_in(rst_in),
            .tick_in(div_tick[d]),
            .sync_in(st_reg.resync[d / DIVS_PER_PLL]),
            .ratio_in(cur.div_ratio[d]),
            .delay_in(cur.div_delay[d]),
            .clk_out(div_clk[d])
        );
    end

    // pick one of eight divider taps of the bank's pll pair
    function automatic logic pick(input logic [ND-1:0] c, input int base, input logic [2:0] s);
        logic [7:0] taps;
        taps = c[base +: 8];
        return taps[s];
    endfunction

    // -----------------------------------------------------------
    // control and configuration state
    // -----------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.resync = '0;
        st_next.refused = 1'b0;
        // target address match and reprogramming
        st_next.match = (bus_addr_in == st_reg.addr);
        if (addr_wr_in) begin
            st_next.addr = addr_new_in;
        end
        // one request per cycle is taken, well above the fast-mode rate
        // configuration writes; protection only guards the user profile
        if (req_in.wr) begin
            if (req_in.profile) begin
                if (prot_in == PROT_WRITE || prot_in == PROT_BOTH) begin
                    st_next.refused = 1'b1;
                end else begin
                    for (int i = 0; i < ND; i++) begin
                        if (part_mask_in[i % NUM_SETS]) begin
                            st_next.profile.div_ratio[i] = req_in.data.div_ratio[i];
                        end
                    end
                end
            end else begin
                st_next.sets[req_in.set_idx] = req_in.data;
                if (req_in.set_idx == st_reg.active) begin
                    st_next.resync = '1;
                end
            end
        end
        if (req_in.rd) begin
            if (req_in.profile) begin
                if (prot_in == PROT_READ || prot_in == PROT_BOTH) begin
                    st_next.refused = 1'b1;
                    st_next.rd = '0;
                end else begin
                    st_next.rd = st_reg.profile;
                end
            end else begin
                st_next.rd = st_reg.sets[req_in.set_idx];
            end
        end
        // multifunction pins
        st_next.oe = 1'b1;
        st_next.pdown = 1'b0;
        st_next.spread = 1'b0;
        st_next.fsel_hold = 1'b0;
        for (int m = 0; m < NUM_MF; m++) begin
            unique case (mf_func_in[m])
                MF_FREQ_CHANGE: st_next.fsel_hold = st_next.fsel_hold | ~mf_pins_in[m];
                MF_OUT_ENABLE: st_next.oe = st_next.oe & mf_pins_in[m];
                MF_POWER_DOWN: st_next.pdown = st_next.pdown | mf_pins_in[m];
                MF_SPREAD_ON: st_next.spread = st_next.spread | mf_pins_in[m];
            endcase
        end
        // set switch on an accepted select change
        if (fs_change && !st_reg.fsel_hold) begin
            st_next.active = fs_level;
            st_next.resync = '1;
        end
        // trim clamp, spread cannot coexist with vcfs
        if (control_voltage_input_in > VCFS_MAX) begin
            st_next.trim = VCFS_MAX;
        end else if (control_voltage_input_in < -VCFS_MAX) begin
            st_next.trim = -VCFS_MAX;
        end else begin
            st_next.trim = control_voltage_input_in;
        end
        // spread gated here so the pin comes straight from a flip-flop
        st_next.spread = st_next.spread & (st_next.trim == '0);
        // output routing
        for (int o = 0; o < BANK_OUTS; o++) begin
            st_next.bank_a[o] = st_next.oe & ~st_reg.pdown & pick(div_clk, 0, cur.out_sel[o]);
            st_next.bank_b[o] = st_next.oe & ~st_reg.pdown
                                & pick(div_clk, 8, cur.out_sel[BANK_OUTS + o]);
        end
        st_next.diff_a = cur.out_diff[DUAL_OUTS-1:0];
        st_next.diff_b = cur.out_diff[2*DUAL_OUTS-1:DUAL_OUTS];
        st_next.fb = cur.fb_from_ref2;
        // low-frequency counter from the core clock
        if (st_reg.lf_cnt + 1'b1 >= cur.lf_ratio) begin
            st_next.lf_cnt = '0;
            st_next.lf = ~st_reg.lf & ~st_reg.pdown;
        end else begin
            st_next.lf_cnt = st_reg.lf_cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_reg <= '0;
            st_reg.addr <= DEFAULT_BUS_ADDR;
            st_reg.active <= SET_RESET;
            for (int i = 0; i < NUM_SETS; i++) begin
                for (int d = 0; d < ND; d++) begin
                    st_reg.sets[i].div_ratio[d] <= DIV_RESET;
                end
            end
        end else begin
            st_reg <= st_next;
        end
    end

    assign addr_match_out = st_reg.match;
    assign bus_addr_out = st_reg.addr;
    assign rd_data_out = st_reg.rd;
    assign req_refused_out = st_reg.refused;
    assign active_set_out = st_reg.active;
    assign bank_a_out = st_reg.bank_a;
    assign bank_b_out = st_reg.bank_b;
    assign bank_a_diff_out = st_reg.diff_a;
    assign bank_b_diff_out = st_reg.diff_b;
    assign pll_fb_ref2_out = st_reg.fb;
    assign pll1_frac_trim_out = st_reg.trim;
    assign spread_en_out = st_reg.spread;
    assign power_down_out = st_reg.pdown;
    assign lf_clk_out = st_reg.lf;

    // -----------------------------------------------------------
    // checks
    // -----------------------------------------------------------
    sequence sel_seen;
        fs_change && !st_reg.fsel_hold;
    endsequence
    set_switch_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        sel_seen |=> active_set_out == $past(fs_level)) else $error("set not switched");
    set_resync_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        sel_seen |=> st_reg.resync == '1) else $error("dividers not restarted");
    addr_match_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (bus_addr_in == bus_addr_out && !addr_wr_in) |=> addr_match_out)
        else $error("own address missed");
    wr_prot_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (req_in.wr && req_in.profile && prot_in == PROT_WRITE) |=> req_refused_out)
        else $error("protected write taken");
    rd_prot_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (req_in.rd && req_in.profile && prot_in == PROT_BOTH) |=> rd_data_out == '0)
        else $error("protected read leaked");
    set_store_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (req_in.wr && !req_in.profile) |=> st_reg.sets[$past(req_in.set_idx)] == $past(req_in.data))
        else $error("set write lost");
    trim_range_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        pll1_frac_trim_out <= VCFS_MAX && pll1_frac_trim_out >= -VCFS_MAX)
        else $error("trim out of range");
    pdown_quiet_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        power_down_out [*2] |=> bank_a_out == '0 && bank_b_out == '0)
        else $error("outputs run in power down");
    fb_route_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        1'b1 |=> pll_fb_ref2_out == $past(cur.fb_from_ref2))
        else $error("feedback select stale");
    // pin functions, one cycle after the pins
    oe_quiet_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (mf_func_in[0] == MF_OUT_ENABLE && !mf_pins_in[0])
        |=> bank_a_out == '0 && bank_b_out == '0)
        else $error("outputs run while disabled");
    spread_excl_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        spread_en_out |-> pll1_frac_trim_out == '0)
        else $error("spread on during trim");
    trim_pass_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (control_voltage_input_in <= VCFS_MAX && control_voltage_input_in >= -VCFS_MAX)
        |=> pll1_frac_trim_out == $past(control_voltage_input_in))
        else $error("in-range trim altered");
    // serial side requests
    addr_prog_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        addr_wr_in |=> bus_addr_out == $past(addr_new_in))
        else $error("target address not taken");
    read_prot_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (req_in.rd && req_in.profile && prot_in == PROT_READ)
        |=> req_refused_out && rd_data_out == '0)
        else $error("read-protected profile leaked");
    wr_resync_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (req_in.wr && !req_in.profile && req_in.set_idx == active_set_out)
        |=> st_reg.resync == '1)
        else $error("active set rewrite not restarted");
endmodule

// [rtl/clkgen_pkg.sv]
// Purpose: shared constants and carrier types for the clock generator control
// Assumes: one 20 MHz core clock; all pins are synchronous to it
// Notes: configuration sets are flip-flop images; no bus, fields are plain ports
package clkgen_pkg;
    localparam int NUM_PLL = 4;
    localparam int DIVS_PER_PLL = 4;
    localparam int NUM_SETS = 8;
    localparam int SET_IDX_W = 3;
    localparam int BANK_OUTS = 6;
    localparam int DUAL_OUTS = 4;
    localparam int DIV_W = 8;
    localparam int DLY_W = 3;
    localparam int LF_W = 16;
    localparam int CORE_CLK_KHZ = 20000;
    // debounce time in microseconds and its cycle count
    localparam int DEBOUNCE_US = 10;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_US * CORE_CLK_KHZ) / 1000;
    localparam int DEB_CNT_W = 9;
    // fast-mode bit rate ceiling, kb/s
    localparam int BUS_RATE_KBPS = 400;
    localparam logic [6:0] DEFAULT_BUS_ADDR = 7'h69;
    // vcfs span in ppm, step limit for the fractional trim
    localparam int VCFS_PPM = 120;
    localparam logic signed [9:0] VCFS_MAX = 10'sh078;
    localparam logic [DIV_W-1:0] DIV_RESET = 8'h01;
    localparam logic [SET_IDX_W-1:0] SET_RESET = 3'h0;

    typedef enum logic [1:0] {
        MF_FREQ_CHANGE,
        MF_OUT_ENABLE,
        MF_POWER_DOWN,
        MF_SPREAD_ON
    } mf_func_e;

    typedef enum logic [1:0] {
        PROT_NONE,
        PROT_READ,
        PROT_WRITE,
        PROT_BOTH
    } prot_e;

    // one configuration set
    typedef struct packed {
        logic [NUM_PLL*DIVS_PER_PLL-1:0][DIV_W-1:0] div_ratio;
        logic [NUM_PLL*DIVS_PER_PLL-1:0][DLY_W-1:0] div_delay;
        logic [2*BANK_OUTS-1:0][2:0] out_sel;
        logic [2*DUAL_OUTS-1:0] out_diff;
        logic [NUM_PLL-1:0] fb_from_ref2;
        logic [LF_W-1:0] lf_ratio;
    } cfg_set_s;

    // configuration write/read port from the serial engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic profile;
        logic [SET_IDX_W-1:0] set_idx;
        cfg_set_s data;
    } cfg_req_s;
endpackage

// [rtl/sel_debounce.sv]
// Purpose: synchronise and debounce one select pin group
// Assumes: pins synchronous per house rule, extra stage guards metastability
// Notes: emits a one-cycle change pulse once the level is stable
`timescale 1ns/10ps
module sel_debounce
    import clkgen_pkg::*;
#(
    parameter int W = 3
) (
    input wire logic core_clk_in, // core clock
    input wire logic rst_in, // synchronous reset
    input wire logic [W-1:0] pins_in, // raw select pins
    output logic [W-1:0] level_out, // debounced level
    output logic change_out // pulse on accepted change
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] stable;
        logic [DEB_CNT_W-1:0] cnt;
        logic chg;
    } st_s;
    st_s st_reg, st_next;

    // count while the sampled level differs from the accepted one
    always_comb begin
        st_next = st_reg;
        st_next.s1 = pins_in;
        st_next.s2 = st_reg.s1;
        st_next.chg = 1'b0;
        if (st_reg.s2 == st_reg.stable) begin
            st_next.cnt = '0;
        end else if (st_reg.cnt == DEB_CNT_W'(DEBOUNCE_CYC - 1)) begin
            st_next.stable = st_reg.s2;
            st_next.chg = 1'b1;
            st_next.cnt = '0;
        end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.stable;
    assign change_out = st_reg.chg;

    // a change pulse lasts exactly one cycle
    one_pulse_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        change_out |=> !change_out) else $error("change pulse longer than one cycle");
endmodule

// [rtl/out_divider.sv]
// Purpose: one output divider with synchronised restart and delay stage
// Assumes: ratio 0 or 1 both pass the source toggle rate
// Notes: restart lines up all dividers of one pll
`timescale 1ns/10ps
module out_divider
    import clkgen_pkg::*;
(
    input wire logic core_clk_in, // core clock
    input wire logic rst_in, // synchronous reset
    input wire logic tick_in, // source clock edge from pll
    input wire logic sync_in, // group restart
    input wire logic [DIV_W-1:0] ratio_in, // half-period in ticks
    input wire logic [DLY_W-1:0] delay_in, // delay stages
    output logic clk_out // delayed divided clock
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic q;
        logic [(1<<DLY_W)-1:0] dly;
    } st_s;
    st_s st_reg, st_next;

    // toggle only at count end; a ratio lowered below the running count ends the half-period at the next tick
    always_comb begin
        st_next = st_reg;
        if (sync_in) begin
            st_next.cnt = '0;
            st_next.q = 1'b0;
        end else if (tick_in) begin
            if (st_reg.cnt + 1'b1 >= ratio_in) begin
                st_next.cnt = '0;
                st_next.q = ~st_reg.q;
            end else begin
                st_next.cnt = st_reg.cnt + 1'b1;
            end
        end
        st_next.dly = {st_reg.dly[(1<<DLY_W)-2:0], st_reg.q};
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign clk_out = (delay_in == '0) ? st_reg.q : st_reg.dly[delay_in - 1'b1];
endmodule

// [dv/cfg_host_model.sv]
// Purpose: far-side host that hands decoded config requests to the block
// Assumes: the bench queues one request at a time through go_in
// Notes: drives only at the falling edge, so the block samples settled values
`timescale 1ns/10ps
module cfg_host_model
    import clkgen_pkg::*;
(
    input wire logic core_clk_in, // core clock
    input wire logic rst_in, // synchronous reset
    input wire logic go_in, // bench asks for one request
    input wire cfg_req_s cmd_in, // request to present
    input wire logic [6:0] target_in, // address the host sends
    output cfg_req_s req_out, // request toward the block
    output logic [6:0] bus_addr_out // address seen on the bus
);
    // ---------------------------------------------
    // request launch
    // ---------------------------------------------
    // one request per go cycle, up to one per core cycle, far above the bus ceiling
    always @(negedge core_clk_in) begin
        req_out <= (go_in && !rst_in) ? cmd_in : '0;
        bus_addr_out <= target_in; // host addresses the device by its target
    end
endmodule

// [dv/clock_gen_config_control_tb.sv]
// Purpose: self-checking bench for the clock generator control
// Assumes: host model in front of the config port, pll ticks from a toggle
// Notes: bank clocks are checked for alignment, activity and gating only; routing needs an analog reference model
`timescale 1ns/10ps
module clock_gen_config_control_tb;
    import clkgen_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [2:0] freq_select_pins_in = 3'h0;
    logic [1:0] mf_pins_in = 2'h0;
    mf_func_e [1:0] mf_func_in = '{MF_SPREAD_ON, MF_POWER_DOWN};
    logic [3:0] pll_tick_in = 4'h0;
    logic ref2_tick_in = 1'b0;
    logic signed [9:0] cv_in = 10'sh000;
    logic addr_wr_in = 1'b0;
    logic [6:0] addr_new_in = 7'h00;
    prot_e prot_in = PROT_NONE;
    logic go = 1'b0;
    cfg_req_s cmd = '0;
    logic [6:0] target = 7'h69;
    cfg_req_s req;
    logic [6:0] bus_addr;
    logic addr_match, refused, spread, pdown;
    logic [6:0] cur_addr;
    cfg_set_s rd_data;
    logic [2:0] active;
    logic signed [9:0] trim;
    logic [5:0] bank_a, bank_b;
    logic [3:0] diff_a, diff_b, fb;
    logic lf;
    logic [7:0] part_mask = 8'hff;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    initial forever #25 core_clk_in = ~core_clk_in;
    // ---------------------------------------------
    // stimulus helpers
    // ---------------------------------------------
    // pll ticks alternate so every divider sees real edges
    always @(negedge core_clk_in) begin
        pll_tick_in <= ~pll_tick_in;
        ref2_tick_in <= ~ref2_tick_in;
    end
    // timeout guard, far beyond the debounce waits
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            results();
        end
    end
    cfg_host_model u_host (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .go_in(go), .cmd_in(cmd),
        .target_in(target), .req_out(req), .bus_addr_out(bus_addr)
    );
    clock_gen_config_control #(.NUM_MF(2)) u_dut (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .freq_select_pins_in(freq_select_pins_in),
        .mf_pins_in(mf_pins_in), .mf_func_in(mf_func_in), .pll_tick_in(pll_tick_in),
        .ref2_tick_in(ref2_tick_in), .control_voltage_input_in(cv_in),
        .bus_addr_in(bus_addr), .addr_wr_in(addr_wr_in), .addr_new_in(addr_new_in),
        .prot_in(prot_in), .req_in(req), .part_mask_in(part_mask),
        .addr_match_out(addr_match), .bus_addr_out(cur_addr), .rd_data_out(rd_data),
        .req_refused_out(refused), .active_set_out(active), .bank_a_out(bank_a),
        .bank_b_out(bank_b), .bank_a_diff_out(diff_a), .bank_b_diff_out(diff_b),
        .pll_fb_ref2_out(fb), .pll1_frac_trim_out(trim), .spread_en_out(spread),
        .power_down_out(pdown), .lf_clk_out(lf)
    );
    task automatic chk(input string name, input logic [255:0] exp, input logic [255:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    // one request: raised after an edge, taken at the next, answer watched two cycles
    task automatic host_req(input logic wr, input logic prof, input logic [2:0] idx,
                            input cfg_set_s d, output logic seen);
        @(posedge core_clk_in);
        #1 cmd = '{wr: wr, rd: !wr, profile: prof, set_idx: idx, data: d};
        go = 1'b1;
        @(posedge core_clk_in);
        #1 go = 1'b0;
        @(negedge core_clk_in);
        seen = refused;
        @(negedge core_clk_in);
        seen = seen | refused;
    endtask
    task automatic t_addr();
        chk("addr_default", 7'h69, cur_addr);
        chk("match_default", 1'b1, addr_match);
        @(negedge core_clk_in) begin
            addr_wr_in = 1'b1;
            addr_new_in = 7'h2a;
        end
        @(negedge core_clk_in) addr_wr_in = 1'b0;
        repeat (3) @(negedge core_clk_in);
        chk("addr_prog", 7'h2a, cur_addr);
        chk("old_addr_nomatch", 1'b0, addr_match);
        target = 7'h2a;
        repeat (3) @(negedge core_clk_in);
        chk("new_addr_match", 1'b1, addr_match);
    endtask
    task automatic t_sets();
        cfg_set_s a, b, c, e;
        logic s;
        a = '0;
        b = '0;
        a.div_ratio[0] = 8'h05;
        a.lf_ratio = 16'h1234;
        b.div_ratio[15] = 8'h7e;
        b.out_diff = 8'ha5;
        host_req(1'b1, 1'b0, 3'h2, a, s);
        host_req(1'b1, 1'b0, 3'h7, b, s);
        host_req(1'b0, 1'b0, 3'h2, '0, s);
        chk("set2_read", a, rd_data);
        host_req(1'b0, 1'b0, 3'h7, '0, s);
        chk("set7_read", b, rd_data);
        prot_in = PROT_WRITE;
        host_req(1'b1, 1'b1, 3'h0, a, s);
        chk("prof_wr_refused", 1'b1, s);
        prot_in = PROT_NONE;
        host_req(1'b1, 1'b1, 3'h0, a, s);
        chk("prof_wr_ok", 1'b0, s);
        c = '0;
        c.div_ratio = {16{8'h33}};
        e = '0;
        e.div_ratio[0] = 8'h05;
        e.div_ratio[1] = 8'h33;
        e.div_ratio[9] = 8'h33;
        part_mask = 8'h02;
        host_req(1'b1, 1'b1, 3'h0, c, s);
        part_mask = 8'hff;
        host_req(1'b0, 1'b1, 3'h0, '0, s);
        chk("prof_partial", e, rd_data);
        prot_in = PROT_READ;
        host_req(1'b0, 1'b1, 3'h0, '0, s);
        chk("prof_rd_refused", 1'b1, s);
        chk("prof_rd_blank", '0, rd_data);
        prot_in = PROT_NONE;
    endtask
    task automatic t_select();
        // a short glitch must not move the set; a held level moves it once
        @(negedge core_clk_in) freq_select_pins_in = 3'h5;
        repeat (DEBOUNCE_CYC / 4) @(negedge core_clk_in);
        freq_select_pins_in = 3'h0;
        repeat (DEBOUNCE_CYC + 20) @(negedge core_clk_in);
        chk("glitch_ignored", 3'h0, active);
        freq_select_pins_in = 3'h3;
        repeat (DEBOUNCE_CYC + 20) @(negedge core_clk_in);
        chk("set_switched", 3'h3, active);
        mf_func_in[0] = MF_FREQ_CHANGE;
        freq_select_pins_in = 3'h6;
        repeat (DEBOUNCE_CYC + 20) @(negedge core_clk_in);
        chk("change_gated", 3'h3, active);
        mf_func_in[0] = MF_POWER_DOWN;
    endtask
    task automatic t_mf_trim();
        @(negedge core_clk_in) mf_pins_in = 2'h1;
        repeat (4) @(negedge core_clk_in);
        chk("power_down", 1'b1, pdown);
        mf_pins_in = 2'h2;
        repeat (4) @(negedge core_clk_in);
        chk("power_up", 1'b0, pdown);
        chk("spread_on", 1'b1, spread);
        cv_in = 10'sd50;
        repeat (4) @(negedge core_clk_in);
        chk("trim_pass", 10'sd50, trim);
        chk("spread_off_trim", 1'b0, spread);
        cv_in = 10'sd300;
        repeat (4) @(negedge core_clk_in);
        chk("trim_clamp_hi", VCFS_MAX, trim);
        cv_in = -10'sd300;
        repeat (4) @(negedge core_clk_in);
        chk("trim_clamp_lo", 10'h388, {6'h0, trim});
    endtask
    // rewrite the active set: banks follow tap 0 of their pll pair, all restarted together
    task automatic t_route();
        cfg_set_s r;
        logic s, prev;
        int n, bad, flips;
        r = '0;
        r.out_diff = 8'h5a;
        r.fb_from_ref2 = 4'h3;
        r.lf_ratio = 16'h0004;
        host_req(1'b1, 1'b0, 3'h3, r, s);
        repeat (2) @(negedge core_clk_in);
        chk("diff_a", 4'ha, diff_a);
        chk("diff_b", 4'h5, diff_b);
        chk("fb_ref2", 4'h3, fb);
        bad = 0;
        flips = 0;
        prev = bank_a[0];
        repeat (8) begin
            @(negedge core_clk_in);
            if (bank_b !== bank_a || (bank_a !== 6'h00 && bank_a !== 6'h3f)) bad++;
            if (bank_a[0] !== prev) flips++;
            prev = bank_a[0];
        end
        chk("bank_aligned", 0, bad);
        chk("bank_running", 1, flips > 2);
        prev = lf;
        n = 0;
        while (lf === prev && n < 20) @(negedge core_clk_in) n++;
        prev = lf;
        n = 0;
        while (lf === prev && n < 20) @(negedge core_clk_in) n++;
        chk("lf_half_period", 4, n);
        mf_func_in[0] = MF_OUT_ENABLE;
        repeat (2) @(negedge core_clk_in);
        bad = 0;
        repeat (8) begin
            @(negedge core_clk_in);
            if (bank_a !== 6'h00 || bank_b !== 6'h00) bad++;
        end
        chk("oe_off_quiet", 0, bad);
        mf_func_in[0] = MF_POWER_DOWN;
    endtask
    task automatic results();
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge core_clk_in);
        rst_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
        t_addr();
        t_sets();
        t_select();
        t_mf_trim();
        t_route();
        results();
    end
endmodule
